// ---- scpc_pkg.sv ----
package scpc_pkg;
  // Data bus width
  localparam int SCPC_DATA_W = 32;
  // System clock rate in MHz
  localparam int SCPC_CLK_MHZ = 50;
  // Recovery time after clock restart, in input clock periods
  localparam int SCPC_RESTART_PERIODS = 8;
  // Least clock run after retune before release, in periods
  localparam int SCPC_RETUNE_PERIODS = 8;
  // Allowed period drift, in picoseconds per period
  localparam int SCPC_DRIFT_PS = 250;
  // Clock period in picoseconds, derived from the rate
  localparam int SCPC_CLK_PS = 1000000 / SCPC_CLK_MHZ;
  // Gap in nanoseconds counted as a stopped input clock
  localparam int SCPC_STALL_NS = 200;
  localparam int SCPC_STALL_CYC = (SCPC_STALL_NS * SCPC_CLK_MHZ) / 1000;
  // Reset value of the held output bank
  localparam logic [31:0] SCPC_HELD_RST = 32'h0000_0000;
  // Power states
  typedef enum logic [1:0] {
    SCPC_NORMAL,
    SCPC_DRAIN,
    SCPC_GRANT,
    SCPC_STOPPED
  } scpc_state_t;
endpackage

// ---- scpc_keeper_mem.sv ----
`timescale 1ns/1ps
// Keeper store: one word of held levels, read data registered
module scpc_keeper_mem
  import scpc_pkg::*;
#(
  parameter int W = SCPC_DATA_W
) (
  input wire logic i_sys_clk,
  input wire logic i_reset_n,
  input wire logic i_wr_en,
  input wire logic [W-1:0] i_wr_data,
  output logic [W-1:0] o_rd_data
);
  // Stored level of each pin
  logic [W-1:0] store_reg;
  logic [W-1:0] store_next;
  // Registered read copy
  logic [W-1:0] rd_reg;
  logic [W-1:0] rd_next;

  // Next values
  always_comb begin
    store_next = i_wr_en ? i_wr_data : store_reg;
    rd_next = store_next;
  end

  // Registers
  always_ff @(posedge i_sys_clk) begin
    if (!i_reset_n) begin
      store_reg <= '0;
      rd_reg <= '0;
    end else begin
      store_reg <= store_next;
      rd_reg <= rd_next;
    end
  end

  assign o_rd_data = rd_reg;
endmodule

// ---- scpc_power_ctrl.sv ----
`timescale 1ns/1ps
// Notes on behaviour
// - Halted clock in grant means stop clock.
// - Back to grant within eight clocks.
// - Stop request released resumes normal execution.
// - Outputs hold entry level while stopped.
// - Hold in grant acknowledges, floats outputs.
// - Hold release restores pre-hold levels.
// - Keepers retain data pin levels.
// - Hold disables keepers, floats data bus.
// - Keeper adopts externally driven new level.
// - Freeze clocks in wait, hold, backoff.
// - External events restore frozen clocks, except in grant and stopped.
// - Idle blocks get frozen clocks.
// - Freezing never changes bus timing.
module scpc_power_ctrl
  import scpc_pkg::*;
#(
  parameter int W = SCPC_DATA_W,
  parameter int STALL_CYC = SCPC_STALL_CYC
) (
  input wire logic i_sys_clk,
  input wire logic i_reset_n,
  // External input clock level, toggling at each edge (pin, async)
  input wire logic i_ext_clk_edge,
  // Stop request pin, active low, async
  input wire logic i_stop_clock_request_n,
  // Hold request, synchronous
  input wire logic i_hold_request,
  input wire logic i_address_hold_request,
  input wire logic i_bus_backoff_n,
  input wire logic i_external_snoop_strobe_n,
  input wire logic i_byte_width_bus_size_n,
  input wire logic i_halfword_bus_size_n,
  input wire logic i_cacheable_enable_n,
  input wire logic i_ready_n,
  input wire logic i_flush_n,
  input wire logic i_system_mgmt_interrupt_n,
  input wire logic i_maskable_interrupt_request,
  input wire logic i_nonmask_interrupt,
  // Core activity from the same clock domain
  input wire logic i_core_busy,
  input wire logic i_wait_cycle,
  input wire logic [W-1:0] i_block_idle,
  // Live core outputs and write data
  input wire logic [W-1:0] i_core_out,
  input wire logic [W-1:0] i_core_data_out,
  input wire logic i_core_data_oe_n,
  // Data pins as seen on the wire
  input wire logic [W-1:0] i_data_bus_pins,
  output logic [W-1:0] o_data_bus_pins,
  output logic o_data_bus_pins_oe_n,
  output logic [W-1:0] o_pins_out,
  output logic o_pins_oe_n,
  output logic o_hold_acknowledge,
  output logic o_stop_grant_ack,
  output logic o_stop_clock_state,
  output logic o_core_run,
  output logic [W-1:0] o_block_clk_en
);
  initial begin
    if (W < 1 || STALL_CYC < 2) $error("scpc: bad parameter");
  end

  localparam int SCW = $clog2(STALL_CYC + 1);
  localparam int RCW = $clog2(SCPC_RESTART_PERIODS + 1);

  // Pin synchronisers: three stages, change once stages two and three agree
  logic [2:0] stp_sync_reg, stp_sync_next;
  logic [2:0] edg_sync_reg, edg_sync_next;
  logic stp_req_reg, stp_req_next; // Filtered stop request, active high
  logic edg_lvl_reg, edg_lvl_next; // Filtered input clock level
  logic edge_seen; // One input clock period passed

  always_comb begin
    stp_sync_next = {stp_sync_reg[1:0], ~i_stop_clock_request_n};
    edg_sync_next = {edg_sync_reg[1:0], i_ext_clk_edge};
    stp_req_next = (stp_sync_reg[1] == stp_sync_reg[2]) ? stp_sync_reg[2] : stp_req_reg;
    edg_lvl_next = (edg_sync_reg[1] == edg_sync_reg[2]) ? edg_sync_reg[2] : edg_lvl_reg;
    // Rise of the filtered level marks one input clock period
    edge_seen = edg_lvl_next & ~edg_lvl_reg;
  end

  always_ff @(posedge i_sys_clk) begin
    if (!i_reset_n) begin
      stp_sync_reg <= 3'h0;
      edg_sync_reg <= 3'h0;
      stp_req_reg <= 1'b0;
      edg_lvl_reg <= 1'b0;
    end else begin
      stp_sync_reg <= stp_sync_next;
      edg_sync_reg <= edg_sync_next;
      stp_req_reg <= stp_req_next;
      edg_lvl_reg <= edg_lvl_next;
    end
  end

  // Power state machine with clock-stall and restart counters
  scpc_state_t state_reg, state_next;
  logic [SCW-1:0] stall_reg, stall_next; // Cycles since last input clock rise, saturating at STALL_CYC
  logic [RCW-1:0] rst_cnt_reg, rst_cnt_next; // Edges seen since restart
  logic clk_stopped;

  always_comb begin
    state_next = state_reg;
    stall_next = edge_seen ? '0 : ((stall_reg == SCW'(STALL_CYC)) ? stall_reg : stall_reg + SCW'(1));
    clk_stopped = (stall_reg == SCW'(STALL_CYC));
    rst_cnt_next = rst_cnt_reg;
    unique case (state_reg)
      SCPC_NORMAL: begin
        // Request taken; let current work drain first
        if (stp_req_reg) state_next = SCPC_DRAIN;
      end
      SCPC_DRAIN: begin
        if (!i_core_busy) state_next = SCPC_GRANT;
      end
      SCPC_GRANT: begin
        if (!stp_req_reg) state_next = SCPC_NORMAL;
        else if (clk_stopped && !i_hold_request) begin
          state_next = SCPC_STOPPED;
          rst_cnt_next = '0;
        end
      end
      SCPC_STOPPED: begin
        if (edge_seen) begin
          if (rst_cnt_reg == RCW'(SCPC_RESTART_PERIODS - 1)) state_next = SCPC_GRANT;
          rst_cnt_next = rst_cnt_reg + RCW'(1);
        end
      end
    endcase
  end

  always_ff @(posedge i_sys_clk) begin
    if (!i_reset_n) begin
      state_reg <= SCPC_NORMAL;
      stall_reg <= '0;
      rst_cnt_reg <= '0;
    end else begin
      state_reg <= state_next;
      stall_reg <= stall_next;
      rst_cnt_reg <= rst_cnt_next;
    end
  end

  // Low-power states share output holding and keeper behaviour
  logic low_power;
  logic hold_grant; // Hold taken while clock runs in grant
  logic hold_acknowledge_reg, hold_acknowledge_next; // Hold acknowledge, also gates keeper writes
  assign low_power = (state_reg == SCPC_GRANT) || (state_reg == SCPC_STOPPED);
  assign hold_grant = (state_reg == SCPC_GRANT) && i_hold_request;

  // Keeper store: captures entry level, follows external drive
  logic kp_wr;
  logic [W-1:0] kp_wdata;
  logic [W-1:0] kp_level;

  always_comb begin
    kp_wr = 1'b0;
    kp_wdata = i_data_bus_pins;
    if (!low_power) begin
      // Track the last driven level before entering grant
      kp_wr = !i_core_data_oe_n;
      kp_wdata = i_core_data_out;
    end else if (!hold_grant && !hold_acknowledge_reg && (i_data_bus_pins != kp_level)) begin
      kp_wr = 1'b1;
    end
    // no write while hold floats the bus, last hold cycle too
  end

  scpc_keeper_mem #(.W(W)) u_keeper (
    .i_sys_clk(i_sys_clk),
    .i_reset_n(i_reset_n),
    .i_wr_en(kp_wr),
    .i_wr_data(kp_wdata),
    .o_rd_data(kp_level)
  );

  // Pin drivers and acknowledges
  logic [W-1:0] held_reg, held_next; // Output levels frozen at grant entry
  logic [W-1:0] dout_reg, dout_next;
  logic doe_n_reg, doe_n_next;
  logic [W-1:0] pout_reg, pout_next;
  logic poe_n_reg, poe_n_next;
  logic ack_reg, ack_next;
  logic stop_reg, stop_next;

  always_comb begin
    held_next = low_power ? held_reg : i_core_out;
    pout_next = low_power ? held_reg : i_core_out;
    dout_next = low_power ? kp_level : i_core_data_out;
    doe_n_next = low_power ? 1'b0 : i_core_data_oe_n;
    poe_n_next = 1'b0;
    hold_acknowledge_next = hold_grant;
    if (hold_grant) begin
      poe_n_next = 1'b1;
      doe_n_next = 1'b1;
    end
    // levels return after hold via held_reg and kp_level
    ack_next = (state_next == SCPC_GRANT) || (state_next == SCPC_STOPPED);
    stop_next = (state_next == SCPC_STOPPED);
  end

  always_ff @(posedge i_sys_clk) begin
    if (!i_reset_n) begin
      held_reg <= SCPC_HELD_RST;
      dout_reg <= '0;
      doe_n_reg <= 1'b1;
      pout_reg <= SCPC_HELD_RST;
      poe_n_reg <= 1'b0;
      hold_acknowledge_reg <= 1'b0;
      ack_reg <= 1'b0;
      stop_reg <= 1'b0;
    end else begin
      held_reg <= held_next;
      dout_reg <= dout_next;
      doe_n_reg <= doe_n_next;
      pout_reg <= pout_next;
      poe_n_reg <= poe_n_next;
      hold_acknowledge_reg <= hold_acknowledge_next;
      ack_reg <= ack_next;
      stop_reg <= stop_next;
    end
  end

  // Auto clock freeze
  logic [4:0] evt_sync_reg, evt_mid_reg, evt_last_reg; // Async pins, three stages
  logic [4:0] evt_mid_next, evt_sync_next, evt_last_next;
  logic [3:0] size_prev_reg, size_prev_next; // Last size, cacheable, backoff levels; backoff wakes on change only
  logic wake; // Event that must restore clocks at once
  logic freeze_cond;
  logic run_reg, run_next;
  logic [W-1:0] blk_en_reg, blk_en_next;

  always_comb begin
    evt_sync_next = {i_maskable_interrupt_request, i_nonmask_interrupt,
                     ~i_system_mgmt_interrupt_n, ~i_flush_n, 1'b0};
    evt_mid_next = evt_sync_reg;
    evt_last_next = evt_mid_reg;
    size_prev_next = {i_byte_width_bus_size_n, i_halfword_bus_size_n, i_cacheable_enable_n, i_bus_backoff_n};
    wake = !i_ready_n || !i_external_snoop_strobe_n
        || (|(evt_mid_reg & evt_last_reg)) || (size_prev_next != size_prev_reg);
    freeze_cond = i_wait_cycle || hold_acknowledge_reg || i_address_hold_request || !i_bus_backoff_n;
    // wake overrides freeze, run follows on the next clock, no lost work
    run_next = !low_power && (wake || !freeze_cond);
    blk_en_next = (run_next && !wake) ? ~i_block_idle : {W{run_next}};
  end

  always_ff @(posedge i_sys_clk) begin
    if (!i_reset_n) begin
      evt_sync_reg <= 5'h00;
      evt_mid_reg <= 5'h00;
      evt_last_reg <= 5'h00;
      size_prev_reg <= 4'hF;
      run_reg <= 1'b1;
      blk_en_reg <= '1;
    end else begin
      evt_sync_reg <= evt_sync_next;
      evt_mid_reg <= evt_mid_next;
      evt_last_reg <= evt_last_next;
      size_prev_reg <= size_prev_next;
      run_reg <= run_next;
      blk_en_reg <= blk_en_next;
    end
  end

  assign o_data_bus_pins = dout_reg;
  assign o_data_bus_pins_oe_n = doe_n_reg;
  assign o_pins_out = pout_reg;
  assign o_pins_oe_n = poe_n_reg;
  assign o_hold_acknowledge = hold_acknowledge_reg;
  assign o_stop_grant_ack = ack_reg;
  assign o_stop_clock_state = stop_reg;
  assign o_core_run = run_reg;
  assign o_block_clk_en = blk_en_reg;
endmodule

// ---- scpc_checker.sv ----
`timescale 1ns/1ps
// Port-level watch on the power control block
module scpc_checker (
  input wire logic i_sys_clk,
  input wire logic i_reset_n,
  input wire logic i_ext_clk_edge,
  input wire logic i_stop_clock_request_n,
  input wire logic i_hold_request,
  input wire logic i_core_busy,
  input wire logic [31:0] i_data_bus_pins,
  input wire logic [31:0] o_data_bus_pins,
  input wire logic o_data_bus_pins_oe_n,
  input wire logic [31:0] o_pins_out,
  input wire logic o_pins_oe_n,
  input wire logic o_hold_acknowledge,
  input wire logic o_stop_grant_ack,
  input wire logic o_stop_clock_state
);
  logic edge_q; // Last sampled input clock
  logic [4:0] edge_cnt; // Input clock rises while stopped
  // Counts restart edges; cleared outside the stopped state
  always_ff @(posedge i_sys_clk) begin
    edge_q <= i_ext_clk_edge;
    if (!i_reset_n || !o_stop_clock_state) begin
      edge_cnt <= 5'h00;
    end else if (i_ext_clk_edge && !edge_q) begin
      edge_cnt <= edge_cnt + 5'h01;
    end
  end
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (!i_reset_n);
  // Grant held with no hold in progress
  sequence held_grant;
    o_stop_grant_ack && !o_hold_acknowledge;
  endsequence
  a_hold_ack_rise: assert property (
    o_stop_grant_ack && !o_stop_clock_state && !i_stop_clock_request_n && i_hold_request |=> o_hold_acknowledge)
    else $error("hold not acknowledged in grant");
  a_hold_only_grant: assert property (o_hold_acknowledge |-> o_stop_grant_ack)
    else $error("hold acknowledged outside grant");
  a_hold_floats_all: assert property (
    o_hold_acknowledge |-> o_pins_oe_n && o_data_bus_pins_oe_n)
    else $error("pins driven during hold");
  a_pins_held_grant: assert property (held_grant ##1 held_grant |-> $stable(o_pins_out))
    else $error("outputs moved in grant");
  a_keeper_drives_bus: assert property (held_grant ##1 held_grant |-> !o_data_bus_pins_oe_n)
    else $error("keeper not driving");
  a_keeper_adopts_level: assert property (
    (o_stop_grant_ack && !o_hold_acknowledge && !i_hold_request && $stable(i_data_bus_pins))[*3]
    |-> o_data_bus_pins == i_data_bus_pins)
    else $error("keeper ignored wire level");
  a_release_drops_ack: assert property (i_stop_clock_request_n[*6] |-> !o_stop_grant_ack)
    else $error("grant kept after release");
  a_busy_blocks_ack: assert property (!o_stop_grant_ack && i_core_busy |=> !o_stop_grant_ack)
    else $error("grant while busy");
  a_restart_bound: assert property (edge_cnt <= 5'h09)
    else $error("restart took too long");
endmodule
bind scpc_power_ctrl scpc_checker u_chk (.i_sys_clk, .i_reset_n, .i_ext_clk_edge, .i_stop_clock_request_n,
  .i_hold_request, .i_core_busy, .i_data_bus_pins, .o_data_bus_pins, .o_data_bus_pins_oe_n, .o_pins_out,
  .o_pins_oe_n, .o_hold_acknowledge, .o_stop_grant_ack, .o_stop_clock_state);

// ---- scpc_sys_model.sv ----
`timescale 1ns/1ps
// External system: input clock and stop request
module scpc_sys_model (
  input wire logic i_sys_clk,
  input wire logic i_want_stop,
  input wire logic i_halt,
  input wire logic i_grant,
  output logic o_ext_clk_edge,
  output logic o_stop_n
);
  int half = 2; // Half period in system clocks
  int ph = 0; // Phase within half period
  int periods = 0; // Periods since retune
  initial begin
    o_ext_clk_edge = 1'b0;
    o_stop_n = 1'b1;
  end
  always @(negedge i_sys_clk) begin
    if (i_grant && half == 2) begin
      half = 3;
      periods = 0;
    end
    // period lengthened once at grant, halted only in grant
    if (!i_halt || !i_grant) begin
      ph = ph + 1;
      if (ph >= half) begin
        ph = 0;
        o_ext_clk_edge = !o_ext_clk_edge;
        if (o_ext_clk_edge) periods = periods + 1;
      end
    end
    // eight periods before release, idle high
    if (i_want_stop) o_stop_n = 1'b0;
    else if (periods >= 8) o_stop_n = 1'b1;
  end
endmodule

// ---- tb.sv ----
`timescale 1ns/1ps
// Self-checking bench for the power control block
module tb;
  import scpc_pkg::*;
  logic clk, rst_n, want_stop, halt, hold, busy, wait_cyc, core_oe_n, ext_en;
  logic [10:0] ev; // Bus and wake inputs, idle levels in EV_IDLE
  logic [31:0] idle, core_out, core_data, ext_val, float_val, wire_lvl, d_out, pins, blk_en;
  logic edge_w, stop_n, d_oe_n, p_oe_n, hold_acknowledge, ack, stopped, run;
  int fails, tests_run, cyc, n;
  localparam logic [10:0] EV_IDLE = 11'h4FE;
  // Released wire shows a changing pattern
  assign wire_lvl = ext_en ? ext_val : (!d_oe_n ? d_out : float_val);
  always @(posedge clk) float_val <= ~wire_lvl;
  scpc_sys_model u_sys (.i_sys_clk(clk), .i_want_stop(want_stop), .i_halt(halt), .i_grant(ack),
    .o_ext_clk_edge(edge_w), .o_stop_n(stop_n));
  scpc_power_ctrl #(.STALL_CYC(16)) u_dut (.i_sys_clk(clk), .i_reset_n(rst_n), .i_ext_clk_edge(edge_w),
    .i_stop_clock_request_n(stop_n), .i_hold_request(hold), .i_address_hold_request(ev[0]),
    .i_bus_backoff_n(ev[1]), .i_external_snoop_strobe_n(ev[2]), .i_byte_width_bus_size_n(ev[3]),
    .i_halfword_bus_size_n(ev[4]), .i_cacheable_enable_n(ev[5]), .i_flush_n(ev[6]),
    .i_system_mgmt_interrupt_n(ev[7]), .i_maskable_interrupt_request(ev[8]), .i_nonmask_interrupt(ev[9]),
    .i_ready_n(ev[10]), .i_core_busy(busy), .i_wait_cycle(wait_cyc), .i_block_idle(idle),
    .i_core_out(core_out), .i_core_data_out(core_data), .i_core_data_oe_n(core_oe_n),
    .i_data_bus_pins(wire_lvl), .o_data_bus_pins(d_out), .o_data_bus_pins_oe_n(d_oe_n), .o_pins_out(pins),
    .o_pins_oe_n(p_oe_n), .o_hold_acknowledge(hold_acknowledge), .o_stop_grant_ack(ack), .o_stop_clock_state(stopped),
    .o_core_run(run), .o_block_clk_en(blk_en));
  task chk1(input string s, input logic e, input logic g);
    tests_run++;
    if (g !== e) begin
      fails++;
      $display("CHECK FAILED %s exp %h got %h", s, e, g);
    end
  endtask
  task chk32(input string s, input logic [31:0] e, input logic [31:0] g);
    tests_run++;
    if (g !== e) begin
      fails++;
      $display("CHECK FAILED %s exp %h got %h", s, e, g);
    end
  endtask
  task wrap_up;
    $display("comparisons %0d mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  // Each wake event must lift a wait freeze
  task t_freeze;
    ev[0] = 1'b1;
    repeat (3) @(negedge clk);
    chk1("core_run address_hold_request", 1'b0, run);
    ev[0] = 1'b0;
    idle = 32'h00FF00FF;
    repeat (3) @(negedge clk);
    chk32("blk_en part idle", 32'hFF00FF00, blk_en);
    idle = 32'h00000000;
    for (int k = 1; k < 11; k++) begin
      wait_cyc = 1'b1;
      idle = 32'hFFFFFFFF;
      repeat (4) @(negedge clk);
      chk32("blk_en idle", 32'h00000000, blk_en);
      chk1("core_run wait", 1'b0, run);
      ev[k] = ~ev[k];
      for (n = 0; n < 6 && blk_en !== 32'hFFFFFFFF; n++) @(negedge clk);
      chk32("blk_en wake", 32'hFFFFFFFF, blk_en);
      ev = EV_IDLE;
      wait_cyc = 1'b0;
      idle = 32'h00000000;
      repeat (6) @(negedge clk);
    end
  endtask
  // Hold refused in normal, grant waits for drain
  task t_grant;
    core_out = 32'hA5A50F0F;
    core_data = 32'h12345678;
    core_oe_n = 1'b0;
    hold = 1'b1;
    repeat (3) @(negedge clk);
    chk1("hold_acknowledge normal", 1'b0, hold_acknowledge);
    hold = 1'b0;
    busy = 1'b1;
    want_stop = 1'b1;
    repeat (12) @(negedge clk);
    chk1("ack busy", 1'b0, ack);
    busy = 1'b0;
    for (n = 0; n < 20 && ack !== 1'b1; n++) @(negedge clk);
    chk1("ack drained", 1'b1, ack);
    core_out = 32'h00000000;
    core_data = 32'hFFFFFFFF;
    repeat (3) @(negedge clk);
    chk32("pins grant", 32'hA5A50F0F, pins);
    chk1("keeper oe_n", 1'b0, d_oe_n);
    chk32("keeper data", 32'h12345678, d_out);
  endtask
  // Hold in grant floats, release restores
  task t_hold;
    hold = 1'b1;
    repeat (2) @(negedge clk);
    chk1("hold_acknowledge", 1'b1, hold_acknowledge);
    chk1("pins oe_n hold", 1'b1, p_oe_n);
    chk1("data oe_n hold", 1'b1, d_oe_n);
    repeat (3) @(negedge clk);
    hold = 1'b0;
    repeat (2) @(negedge clk);
    chk1("hold_acknowledge off", 1'b0, hold_acknowledge);
    chk1("pins oe_n back", 1'b0, p_oe_n);
    chk32("pins back", 32'hA5A50F0F, pins);
    chk32("data back", 32'h12345678, d_out);
    ext_val = 32'h0F0FF0F0;
    ext_en = 1'b1;
    repeat (5) @(negedge clk);
    ext_en = 1'b0;
    repeat (3) @(negedge clk);
    chk32("data adopted", 32'h0F0FF0F0, d_out);
  endtask
  // Halt and restart the input clock, then release the stop request
  task t_stop;
    halt = 1'b1;
    for (n = 0; n < 40 && stopped !== 1'b1; n++) @(negedge clk);
    chk1("stopped", 1'b1, stopped);
    halt = 1'b0;
    for (n = 0; n < 80 && stopped !== 1'b0; n++) @(negedge clk);
    chk1("left stopped", 1'b0, stopped);
    chk1("ack restart", 1'b1, ack);
    want_stop = 1'b0;
    for (n = 0; n < 200 && ack !== 1'b0; n++) @(negedge clk);
    chk1("ack released", 1'b0, ack);
    @(negedge clk);
    chk1("core runs", 1'b1, run);
  endtask
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  // Hang guard
  always @(posedge clk) begin
    cyc++;
    if (cyc == 5000) begin
      fails++;
      wrap_up();
    end
  end
  initial begin
    {rst_n, want_stop, halt, hold, busy, wait_cyc, ext_en} = 7'h00;
    {ev, core_oe_n} = {EV_IDLE, 1'b1};
    {idle, core_out, core_data, ext_val} = {4{32'h00000000}};
    repeat (6) @(negedge clk);
    chk1("reset data oe_n", 1'b1, d_oe_n);
    chk32("reset pins", 32'h00000000, pins);
    chk1("reset pins oe_n", 1'b0, p_oe_n);
    chk1("reset hold_acknowledge", 1'b0, hold_acknowledge);
    chk1("reset ack", 1'b0, ack);
    chk1("reset stopped", 1'b0, stopped);
    chk1("reset run", 1'b1, run);
    chk32("reset blk_en", 32'hFFFFFFFF, blk_en);
    rst_n = 1'b1;
    repeat (4) @(negedge clk);
    t_freeze();
    t_grant();
    t_hold();
    t_stop();
    wrap_up();
  end
endmodule
